//--- logic/nvm_port_pkg.sv
`default_nettype none
package nvm_port_pkg;
   // Command bytes
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
   localparam logic [7:0] CMD_RD_SIG = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
   // Load actions {load_action_b1, load_action_b0}
   localparam logic [1:0] LA_ADDR = 2'h0;
   localparam logic [1:0] LA_DATA = 2'h1;
   localparam logic [1:0] LA_CMD = 2'h2;
   localparam logic [1:0] LA_IDLE = 2'h3;
   // Byte selects {byte_sel_high, byte_sel_low}
   localparam logic [1:0] BS_LOW = 2'h0;
   localparam logic [1:0] BS_HIGH = 2'h1;
   localparam logic [1:0] BS_EXT = 2'h2;
   localparam logic [1:0] BS_LOCK_RD = 2'h1;
   localparam logic [1:0] BS_FUSE_HIGH_RD = 2'h3;
   // Reset and erased values
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] FUSE_LOW_RESET = 8'hFF;
   localparam logic [7:0] FUSE_HIGH_RESET = 8'hFF;
   localparam logic [7:0] FUSE_EXT_RESET = 8'hFF;
   localparam logic [7:0] LOCK_RESET = 8'hFF;
   localparam logic [7:0] BOOT_LOCK_MASK = 8'h3C;
   localparam int LOCK_LEVEL_A_POS = 0;
   localparam int LOCK_LEVEL_B_POS = 1;
   // Synchroniser vector at rest: strobes idle, load action idle
   localparam logic [15:0] PIN_IDLE = 16'h3C00;
   // Host user-side operations
   localparam logic [2:0] OP_CMD = 3'h0;
   localparam logic [2:0] OP_ADDR = 3'h1;
   localparam logic [2:0] OP_DATA = 3'h2;
   localparam logic [2:0] OP_LATCH = 3'h3;
   localparam logic [2:0] OP_WRITE = 3'h4;
   localparam logic [2:0] OP_READ = 3'h5;
   // Timing in ns, converted to 25 MHz cycles
   localparam int CLK_PERIOD_NS = 40;
   localparam int PULSE_NS = 150;
   localparam int SETUP_NS = 67;
   localparam int HOLD_NS = 67;
   localparam int DATA_VALID_NS = 250;
   localparam int READY_DROP_NS = 1000;
   localparam int WRITE_BUSY_NS = 3700;
   localparam int ERASE_BUSY_NS = 7500000;
   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   function automatic int floor_cyc(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int PULSE_CYC = ceil_cyc(PULSE_NS);
   localparam int SETUP_CYC = ceil_cyc(SETUP_NS);
   localparam int HOLD_CYC = ceil_cyc(HOLD_NS);
   localparam int DATA_VALID_CYC = ceil_cyc(DATA_VALID_NS);
   localparam int READY_DROP_CYC = floor_cyc(READY_DROP_NS);
   localparam int WRITE_BUSY_CYC = ceil_cyc(WRITE_BUSY_NS);
   localparam int ERASE_BUSY_CYC = ceil_cyc(ERASE_BUSY_NS);
endpackage
`default_nettype wire

//--- logic/nvm_port_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nvm_port_if;
   logic load_action_b1;
   logic load_action_b0;
   logic byte_sel_low;
   logic byte_sel_high;
   logic load_clock_pulse;
   logic page_latch_strobe;
   logic wr_n;
   logic oe_n;
   logic ready_flag;
   logic [7:0] host_data;
   logic host_data_oe;
   logic [7:0] dev_data;
   logic dev_data_oe;
   logic [7:0] data_bus;
   // Shared bus level; pulled high when nobody drives
   assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);
   modport device (
      input load_action_b1, load_action_b0, byte_sel_low, byte_sel_high,
      input load_clock_pulse, page_latch_strobe, wr_n, oe_n, data_bus,
      output ready_flag, dev_data, dev_data_oe
   );
   modport host (
      output load_action_b1, load_action_b0, byte_sel_low, byte_sel_high,
      output load_clock_pulse, page_latch_strobe, wr_n, oe_n, host_data, host_data_oe,
      input ready_flag, data_bus
   );
endinterface
`default_nettype wire

//--- logic/nvm_port_device.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_port_device #(
   parameter int FLASH_AW = 10,
   parameter int PAGE_AW = 6,
   parameter int EE_AW = 8,
   parameter int EE_PAGE_AW = 2,
   parameter int ERASE_CYC = nvm_port_pkg::ERASE_BUSY_CYC,
   parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identification value
   parameter logic [7:0] SIG_BYTE1 = 8'h3C, // Arbitrary identification value
   parameter logic [7:0] SIG_BYTE2 = 8'hC3, // Arbitrary identification value
   parameter logic [7:0] CAL_BYTE = 8'h80
)(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   nvm_port_if.device pins,
   output logic [7:0] o_command,
   output logic [7:0] o_fuse_low,
   output logic [7:0] o_fuse_high,
   output logic [7:0] o_fuse_ext,
   output logic [7:0] o_lock_bits,
   output logic o_busy
);
   localparam int FLASH_WORDS = 1 << FLASH_AW;
   localparam int PAGE_WORDS = 1 << PAGE_AW;
   localparam int EE_BYTES = 1 << EE_AW;
   localparam int EE_PAGE_BYTES = 1 << EE_PAGE_AW;

   if (PAGE_AW < 1 || PAGE_AW > 8 || PAGE_AW >= FLASH_AW || FLASH_AW > 24 ||
       EE_PAGE_AW < 1 || EE_PAGE_AW > 8 || EE_PAGE_AW >= EE_AW || EE_AW > 16 || ERASE_CYC < 1) begin : g_bad
      $error("nvm_port_device: unsupported geometry or erase time");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the second stage feeds logic, the third serves only as edge reference
   logic [15:0] pin_raw;
   logic [15:0] sync1;
   logic [15:0] sync2;
   logic [15:0] sync3;
   assign pin_raw = {pins.load_clock_pulse, pins.page_latch_strobe, pins.wr_n, pins.oe_n,
                     pins.load_action_b1, pins.load_action_b0, pins.byte_sel_high, pins.byte_sel_low,
                     pins.data_bus};

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= nvm_port_pkg::PIN_IDLE;
         sync2 <= nvm_port_pkg::PIN_IDLE;
         sync3 <= nvm_port_pkg::PIN_IDLE;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         sync3 <= sync2; // Edge reference, one pulse gives one edge
      end
   end

   // Decoded pins and edges
   wire load_rise = sync2[15] & ~sync3[15];
   wire latch_rise = sync2[14] & ~sync3[14];
   wire wr_fall = ~sync2[13] & sync3[13];
   wire oe_active = ~sync2[12];
   wire [1:0] load_act = sync2[11:10];
   wire [1:0] bsel = sync2[9:8];
   wire [7:0] bus_in = sync2[7:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Programming state
   logic [7:0] cmd;
   logic [7:0] addr_lo;
   logic [7:0] addr_hi;
   logic [7:0] addr_ext;
   logic [7:0] data_lo;
   logic [7:0] data_hi;
   logic [7:0] fuse_low;
   logic [7:0] fuse_high;
   logic [7:0] fuse_ext;
   logic [7:0] lock;
   logic ready;
   logic [31:0] busy_cnt;
   logic [PAGE_WORDS-1:0] page_valid;
   logic [EE_PAGE_BYTES-1:0] ee_valid;

   logic [15:0] flash_mem [FLASH_WORDS];
   logic [15:0] page_buf [PAGE_WORDS];
   logic [7:0] ee_mem [EE_BYTES];
   logic [7:0] ee_buf [EE_PAGE_BYTES];

   // Addresses; page number takes address low top bits when pages are small
   wire [23:0] full_addr = {addr_ext, addr_hi, addr_lo};
   wire [FLASH_AW-1:0] flash_addr = full_addr[FLASH_AW-1:0];
   wire [FLASH_AW-PAGE_AW-1:0] flash_page = flash_addr[FLASH_AW-1:PAGE_AW];
   wire [PAGE_AW-1:0] word_in_page = addr_lo[PAGE_AW-1:0];
   wire [EE_AW-1:0] ee_addr = full_addr[EE_AW-1:0];
   wire [EE_AW-EE_PAGE_AW-1:0] ee_page = ee_addr[EE_AW-1:EE_PAGE_AW];
   wire [EE_PAGE_AW-1:0] byte_in_page = addr_lo[EE_PAGE_AW-1:0];

   // Strobe qualification; strobes during busy are dropped
   wire do_load = load_rise & ready;
   wire load_cmd = do_load && load_act == nvm_port_pkg::LA_CMD;
   wire clear_wr = load_cmd && bus_in == nvm_port_pkg::CMD_NOP;
   wire latch_flash = latch_rise & ready & bsel[0] & (cmd == nvm_port_pkg::CMD_WR_FLASH);
   wire latch_ee = latch_rise & ready & (cmd == nvm_port_pkg::CMD_WR_EEPROM);
   wire wr_go = wr_fall & ready;
   wire go_flash = wr_go && cmd == nvm_port_pkg::CMD_WR_FLASH && bsel == nvm_port_pkg::BS_LOW;
   wire go_ee = wr_go && cmd == nvm_port_pkg::CMD_WR_EEPROM && bsel == nvm_port_pkg::BS_LOW;
   wire go_fuse = wr_go && cmd == nvm_port_pkg::CMD_WR_FUSE && bsel != 2'h3;
   wire go_lock = wr_go && cmd == nvm_port_pkg::CMD_WR_LOCK;
   wire go_erase = wr_go && cmd == nvm_port_pkg::CMD_ERASE;
   wire go_any = go_flash | go_ee | go_fuse | go_lock | go_erase;

   // Mode 3 shields the boot lock bits from any further programming
   wire lock_mode3 = ~lock[nvm_port_pkg::LOCK_LEVEL_A_POS] & ~lock[nvm_port_pkg::LOCK_LEVEL_B_POS];
   wire [7:0] lock_keep = lock_mode3 ? nvm_port_pkg::BOOT_LOCK_MASK : 8'h00;
   wire [7:0] lock_prog = lock & (data_lo | lock_keep);

   ////////////////////////////////////////////////////////////////////////////////
   // Command, address and data latches
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd <= nvm_port_pkg::CMD_NOP;
         addr_lo <= 8'h00;
         addr_hi <= 8'h00;
         addr_ext <= 8'h00;
         data_lo <= 8'h00;
         data_hi <= 8'h00;
      end else if (do_load) begin
         if (load_act == nvm_port_pkg::LA_CMD) begin
            cmd <= bus_in;
         end else if (load_act == nvm_port_pkg::LA_ADDR) begin
            if (bsel == nvm_port_pkg::BS_LOW) begin
               addr_lo <= bus_in;
            end else if (bsel == nvm_port_pkg::BS_HIGH) begin
               addr_hi <= bus_in;
            end else if (bsel == nvm_port_pkg::BS_EXT) begin
               addr_ext <= bus_in;
            end
         end else if (load_act == nvm_port_pkg::LA_DATA) begin
            if (bsel[0]) begin
               data_hi <= bus_in;
            end else begin
               data_lo <= bus_in;
            end
         end
      end
   end

   // Buffer valid masks; a latch in the clearing cycle still counts
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         page_valid <= '0;
         ee_valid <= '0;
      end else begin
         page_valid <= ((clear_wr | go_flash) ? '0 : page_valid) |
                       (latch_flash ? PAGE_WORDS'(1) << word_in_page : '0);
         ee_valid <= ((clear_wr | go_ee) ? '0 : ee_valid) |
                     (latch_ee ? EE_PAGE_BYTES'(1) << byte_in_page : '0);
      end
   end

   // Fuses, lock bits and the busy timer
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fuse_low <= nvm_port_pkg::FUSE_LOW_RESET;
         fuse_high <= nvm_port_pkg::FUSE_HIGH_RESET;
         fuse_ext <= nvm_port_pkg::FUSE_EXT_RESET;
         lock <= nvm_port_pkg::LOCK_RESET;
         ready <= 1'b1;
         busy_cnt <= 32'h0000_0000;
      end else begin
         if (go_fuse && bsel == nvm_port_pkg::BS_LOW) fuse_low <= data_lo;
         if (go_fuse && bsel == nvm_port_pkg::BS_HIGH) fuse_high <= data_lo;
         if (go_fuse && bsel == nvm_port_pkg::BS_EXT) fuse_ext <= data_lo;
         if (go_lock) lock <= lock_prog;
         else if (go_erase) lock <= nvm_port_pkg::LOCK_RESET;
         if (go_any) begin
            ready <= 1'b0;
            busy_cnt <= go_erase ? 32'(ERASE_CYC) : 32'(nvm_port_pkg::WRITE_BUSY_CYC);
         end else if (busy_cnt != 32'h0000_0000) begin
            busy_cnt <= busy_cnt - 32'h0000_0001;
            if (busy_cnt == 32'h0000_0001) ready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Memory arrays; contents are undefined until erased or written
   always_ff @(posedge i_sys_clk) begin
      if (latch_flash) page_buf[word_in_page] <= {data_hi, data_lo};
      if (latch_ee) ee_buf[byte_in_page] <= data_lo;
      if (go_erase) begin
         for (int i = 0; i < FLASH_WORDS; i++) flash_mem[i] <= {2{nvm_port_pkg::ERASED_BYTE}};
         for (int i = 0; i < EE_BYTES; i++) ee_mem[i] <= nvm_port_pkg::ERASED_BYTE;
      end
      if (go_flash) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            if (page_valid[i]) flash_mem[{flash_page, PAGE_AW'(i)}] <= page_buf[i];
         end
      end
      if (go_ee) begin
         for (int i = 0; i < EE_PAGE_BYTES; i++) begin
            if (ee_valid[i]) ee_mem[{ee_page, EE_PAGE_AW'(i)}] <= ee_buf[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read selection
   function automatic logic [7:0] fuse_lock_sel(input logic [1:0] s, input logic [7:0] lo,
                                                input logic [7:0] hi, input logic [7:0] ex,
                                                input logic [7:0] lk);
      return (s == nvm_port_pkg::BS_LOW) ? lo :
             (s == nvm_port_pkg::BS_FUSE_HIGH_RD) ? hi :
             (s == nvm_port_pkg::BS_EXT) ? ex : lk;
   endfunction

   wire [15:0] flash_word = flash_mem[flash_addr];
   wire [7:0] sig_byte = (addr_lo == 8'h00) ? SIG_BYTE0 : (addr_lo == 8'h01) ? SIG_BYTE1 :
                         (addr_lo == 8'h02) ? SIG_BYTE2 : nvm_port_pkg::ERASED_BYTE;
   wire [7:0] cal_byte = (addr_lo == 8'h00) ? CAL_BYTE : nvm_port_pkg::ERASED_BYTE;
   wire [7:0] rd_byte =
      (cmd == nvm_port_pkg::CMD_RD_FLASH) ? (bsel[0] ? flash_word[15:8] : flash_word[7:0]) :
      (cmd == nvm_port_pkg::CMD_RD_EEPROM) ? ee_mem[ee_addr] :
      (cmd == nvm_port_pkg::CMD_RD_FUSE) ? fuse_lock_sel(bsel, fuse_low, fuse_high, fuse_ext, lock) :
      (cmd == nvm_port_pkg::CMD_RD_SIG) ? (bsel[0] ? cal_byte : sig_byte) :
      nvm_port_pkg::ERASED_BYTE;

   // Registered pin drive; bus released three clocks after output enable rises
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pins.dev_data <= 8'h00;
         pins.dev_data_oe <= 1'b0;
         pins.ready_flag <= 1'b1;
         o_busy <= 1'b0;
      end else begin
         pins.dev_data <= rd_byte;
         pins.dev_data_oe <= oe_active;
         pins.ready_flag <= ready & ~go_any;
         o_busy <= ~ready | go_any;
      end
   end

   assign o_command = cmd;
   assign o_fuse_low = fuse_low;
   assign o_fuse_high = fuse_high;
   assign o_fuse_ext = fuse_ext;
   assign o_lock_bits = lock;
endmodule
`default_nettype wire

//--- logic/nvm_port_host.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_port_host (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   nvm_port_if.host pins,
   input wire logic i_req_valid,
   input wire logic [2:0] i_req_op,
   input wire logic [1:0] i_req_sel,
   input wire logic [7:0] i_req_data,
   output logic o_req_ready,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_dev_ready
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_WAIT_LOW, ST_WAIT_HIGH, ST_READ
   } state_type;

   state_type state;
   logic [2:0] op;
   logic [7:0] cnt;
   logic [8:0] sync1;
   logic [8:0] sync2;

   ////////////////////////////////////////////////////////////////////////////////
   // Ready flag and bus come from the device's domain
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= 9'h1FF;
         sync2 <= 9'h1FF;
      end else begin
         sync1 <= {pins.ready_flag, pins.data_bus};
         sync2 <= sync1;
      end
   end

   wire cnt_done = (cnt == 8'h00);
   wire is_write = (op == nvm_port_pkg::OP_WRITE);
   wire is_read = (op == nvm_port_pkg::OP_READ);
   wire [1:0] req_act = (i_req_op == nvm_port_pkg::OP_CMD) ? nvm_port_pkg::LA_CMD :
                        (i_req_op == nvm_port_pkg::OP_ADDR) ? nvm_port_pkg::LA_ADDR :
                        (i_req_op == nvm_port_pkg::OP_DATA) ? nvm_port_pkg::LA_DATA :
                        nvm_port_pkg::LA_IDLE;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: setup, strobe, hold, then optional busy wait
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ST_IDLE;
         op <= nvm_port_pkg::OP_CMD;
         cnt <= 8'h00;
         pins.load_action_b1 <= 1'b1;
         pins.load_action_b0 <= 1'b1;
         pins.byte_sel_high <= 1'b0;
         pins.byte_sel_low <= 1'b0;
         pins.load_clock_pulse <= 1'b0;
         pins.page_latch_strobe <= 1'b0;
         pins.wr_n <= 1'b1;
         pins.oe_n <= 1'b1;
         pins.host_data <= 8'h00;
         pins.host_data_oe <= 1'b1;
         o_req_ready <= 1'b1;
         o_rd_valid <= 1'b0;
         o_rd_data <= 8'h00;
         o_dev_ready <= 1'b1;
      end else begin
         o_rd_valid <= 1'b0;
         o_dev_ready <= sync2[8];
         if (!cnt_done) cnt <= cnt - 8'h01;
         unique case (state)
            ST_IDLE: begin
               if (i_req_valid) begin
                  op <= i_req_op;
                  o_req_ready <= 1'b0;
                  {pins.load_action_b1, pins.load_action_b0} <= req_act;
                  {pins.byte_sel_high, pins.byte_sel_low} <= i_req_sel;
                  pins.host_data <= i_req_data;
                  pins.host_data_oe <= (i_req_op != nvm_port_pkg::OP_READ);
                  cnt <= 8'(nvm_port_pkg::SETUP_CYC);
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_done && is_read) begin
                  pins.oe_n <= 1'b0;
                  cnt <= 8'(nvm_port_pkg::DATA_VALID_CYC);
                  state <= ST_READ;
               end else if (cnt_done) begin
                  pins.load_clock_pulse <= (op <= nvm_port_pkg::OP_DATA);
                  pins.page_latch_strobe <= (op == nvm_port_pkg::OP_LATCH);
                  pins.wr_n <= ~is_write;
                  cnt <= 8'(nvm_port_pkg::PULSE_CYC);
                  state <= ST_PULSE;
               end
            end
            ST_PULSE: begin
               if (cnt_done) begin
                  pins.load_clock_pulse <= 1'b0;
                  pins.page_latch_strobe <= 1'b0;
                  pins.wr_n <= 1'b1;
                  cnt <= 8'(nvm_port_pkg::HOLD_CYC);
                  state <= ST_HOLD;
               end
            end
            ST_READ: begin
               if (cnt_done) begin
                  o_rd_data <= sync2[7:0];
                  o_rd_valid <= 1'b1;
                  pins.oe_n <= 1'b1;
                  cnt <= 8'(nvm_port_pkg::DATA_VALID_CYC); // Bus turnaround
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_done) begin
                  {pins.load_action_b1, pins.load_action_b0} <= nvm_port_pkg::LA_IDLE;
                  pins.host_data_oe <= 1'b1;
                  if (is_write) begin
                     {pins.byte_sel_high, pins.byte_sel_low} <= nvm_port_pkg::BS_LOW;
                     cnt <= 8'(nvm_port_pkg::READY_DROP_CYC);
                     state <= ST_WAIT_LOW;
                  end else begin
                     o_req_ready <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            // Ready may take up to the longest drop time to fall
            ST_WAIT_LOW: begin
               if (cnt_done) state <= ST_WAIT_HIGH;
            end
            ST_WAIT_HIGH: begin
               if (sync2[8]) begin
                  o_req_ready <= 1'b1;
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- test/nvm_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_port_asserts (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic wr_n,
   input wire logic oe_n,
   input wire logic load_clock_pulse,
   input wire logic ready_flag,
   input wire logic dev_data_oe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////
   // Write steps: strobe while ready, then a busy stretch
   sequence seq_strobe;
      $fell(wr_n) && ready_flag;
   endsequence
   sequence seq_busy;
      !ready_flag [*8];
   endsequence
   sequence seq_oe_idle;
      oe_n [*4];
   endsequence
   a_write_goes_busy: assert property (seq_strobe |-> ##3 seq_busy) else $error("no busy after write");
   a_busy_has_cause: assert property ($fell(ready_flag) |-> $past(wr_n, 3) == 1'b0) else $error("busy without strobe");
   a_busy_ends: assert property ($fell(ready_flag) |-> ##[1:100] ready_flag) else $error("busy too long");
   a_no_load_busy: assert property (!ready_flag |-> !load_clock_pulse) else $error("load while busy");
   a_drive_needs_oe: assert property ($rose(dev_data_oe) |-> $past(oe_n, 3) == 1'b0) else $error("drive without oe");
   a_oe_drives: assert property ($fell(oe_n) |-> ##3 dev_data_oe) else $error("bus not driven");
   a_release_bus: assert property ($rose(oe_n) |-> ##3 !dev_data_oe) else $error("bus not released");
   a_idle_undriven: assert property (seq_oe_idle |-> !dev_data_oe) else $error("bus driven idle");
endmodule
`default_nettype wire

//--- test/parallel_nvm_programming_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_nvm_programming_port_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_valid = 1'b0;
   logic [2:0] req_op = 3'h0;
   logic [1:0] req_sel = 2'h0;
   logic [7:0] req_data = 8'h00;
   logic req_ready;
   logic rd_valid;
   logic [7:0] rd_data;
   logic [7:0] command;
   logic [7:0] fuse_low;
   logic [7:0] fuse_high;
   logic [7:0] fuse_ext;
   logic [7:0] lock_bits;
   logic busy;
   logic dev_ready;
   int error_cnt = 0;
   int check_count = 0;
   // Row: op, selects, data byte, expected read byte (reads only)
   logic [23:0] rows [$] = {24'h0_0_80_00, 24'h4_0_00_00, 24'h0_0_40_00, 24'h2_0_A5_00, 24'h4_0_00_00,
      24'h2_0_3C_00, 24'h4_1_00_00, 24'h2_0_96_00, 24'h4_2_00_00, 24'h0_0_04_00, 24'h5_0_00_A5,
      24'h5_3_00_3C, 24'h5_2_00_96, 24'h5_1_00_FF, 24'h0_0_08_00, 24'h1_0_00_00, 24'h5_0_00_5A,
      24'h5_1_00_80, 24'h1_0_01_00, 24'h5_0_00_3C, 24'h1_0_02_00, 24'h5_0_00_C3, 24'h0_0_10_00,
      24'h1_0_05_00, 24'h2_0_34_00, 24'h2_1_12_00, 24'h3_1_00_00, 24'h1_1_00_00, 24'h1_2_00_00,
      24'h4_0_00_00, 24'h0_0_00_00, 24'h0_0_02_00, 24'h1_0_05_00, 24'h5_0_00_34, 24'h5_1_00_12,
      24'h1_0_06_00, 24'h5_0_00_FF, 24'h0_0_11_00, 24'h1_1_00_00, 24'h1_0_07_00, 24'h2_0_C8_00,
      24'h3_0_00_00, 24'h4_0_00_00, 24'h0_0_03_00, 24'h5_0_00_C8, 24'h0_0_10_00, 24'h3_1_00_00,
      24'h0_0_00_00, 24'h0_0_10_00, 24'h4_0_00_00, 24'h0_0_02_00, 24'h5_0_00_FF};
   always #20 sys_clk = ~sys_clk;
   ////////////////////////////////////////
   // Both ends face each other; short erase keeps the run brief
   nvm_port_if pins_if();
   nvm_port_device #(.ERASE_CYC(20)) i_nvm_port_device (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .pins(pins_if),
      .o_command(command), .o_fuse_low(fuse_low), .o_fuse_high(fuse_high), .o_fuse_ext(fuse_ext),
      .o_lock_bits(lock_bits), .o_busy(busy));
   nvm_port_host i_nvm_port_host (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .pins(pins_if), .i_req_valid(req_valid),
      .i_req_op(req_op), .i_req_sel(req_sel), .i_req_data(req_data), .o_req_ready(req_ready),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_dev_ready(dev_ready));
   nvm_port_asserts i_nvm_port_asserts (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .wr_n(pins_if.wr_n),
      .oe_n(pins_if.oe_n),
      .load_clock_pulse(pins_if.load_clock_pulse), .ready_flag(pins_if.ready_flag),
      .dev_data_oe(pins_if.dev_data_oe));
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One user request; waits for the port, then for read data if any
   task automatic run(input logic [23:0] r);
      int n;
      n = 0;
      do @(negedge sys_clk); while (req_ready !== 1'b1 && ++n < 400);
      chk("port ready", {7'h00, req_ready}, 8'h01);
      @(posedge sys_clk);
      req_op <= r[22:20];
      req_sel <= r[17:16];
      req_data <= r[15:8];
      req_valid <= 1'b1;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      if (r[22:20] == nvm_port_pkg::OP_READ) begin
         n = 0;
         do @(negedge sys_clk); while (rd_valid !== 1'b1 && ++n < 40);
         chk("read strobe", {7'h00, rd_valid}, 8'h01);
         chk("read byte", rd_data, r[7:0]);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////
   // Table, then lock mode 3, erase and a reset during a write
   initial begin
      repeat (10) @(posedge sys_clk);
      chk("ready in reset", {7'h00, pins_if.ready_flag}, 8'h01);
      chk("bus in reset", {7'h00, pins_if.dev_data_oe}, 8'h00);
      rst_n <= 1'b1;
      foreach (rows[i]) run(rows[i]);
      chk("fuse low", fuse_low, 8'hA5);
      chk("fuse high", fuse_high, 8'h3C);
      chk("fuse ext", fuse_ext, 8'h96);
      run(24'h0_0_20_00);
      run(24'h2_0_FC_00);
      chk("command", command, 8'h20);
      run(24'h4_0_00_00);
      run(24'h2_0_C3_00);
      run(24'h4_0_00_00);
      run(24'h0_0_04_00);
      run(24'h5_1_00_FC);
      chk("lock bits", lock_bits, 8'hFC);
      run(24'h0_0_80_00);
      run(24'h4_0_00_00);
      run(24'h0_0_04_00);
      run(24'h5_1_00_FF);
      run(24'h5_0_00_A5);
      run(24'h0_0_40_00);
      run(24'h4_0_00_00);
      repeat (30) @(posedge sys_clk);
      chk("busy mid write", {7'h00, pins_if.ready_flag}, 8'h00);
      chk("busy flag", {7'h00, busy}, 8'h01);
      chk("host sees busy", {7'h00, dev_ready}, 8'h00);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("ready after reset", {7'h00, pins_if.ready_flag}, 8'h01);
      chk("busy after reset", {7'h00, busy}, 8'h00);
      rst_n <= 1'b1;
      // Port must serve requests again once reset is lifted
      run(24'h0_0_04_00);
      run({8'h50, 8'h00, nvm_port_pkg::FUSE_LOW_RESET});
      conclude();
   end
   // Watchdog sized well above the expected few thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      conclude();
   end
endmodule
`default_nettype wire
